// ==== shared/pvcr_pkg.sv ====
package pvcr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] PVCR_IDX_TENBT = 8'h12;
  localparam logic [7:0] PVCR_IDX_PWDN = 8'h13;
  localparam logic [7:0] PVCR_IDX_SPEC = 8'h14;
  // ten_base_t_config_status fields
  localparam int PVCR_TB_LINK_PULSE = 14;
  localparam int PVCR_TB_HEARTBEAT = 13;
  localparam int PVCR_TB_SQUELCH = 12;
  localparam int PVCR_TB_JABBER = 11;
  localparam int PVCR_TB_RSVD_RW = 10;
  localparam int PVCR_TB_POLARITY = 0;
  localparam logic [15:0] PVCR_TB_WMASK = 16'h7C00;
  localparam logic [15:0] PVCR_TB_RESET = 16'h7800;
  // power_down_test_control: nine fields in bits 8..0
  localparam int PVCR_PD_FIELDS = 9;
  localparam logic [15:0] PVCR_PD_WMASK = 16'h01FF;
  localparam logic [15:0] PVCR_PD_RESET = 16'h0000;
  // specified_configuration fields
  localparam int PVCR_SC_TEST_A = 15;
  localparam int PVCR_SC_TEST_B = 14;
  localparam int PVCR_SC_FORCE_SD = 13;
  localparam int PVCR_SC_FEF = 12;
  localparam int PVCR_SC_NEG_FULL_PWR = 11;
  localparam int PVCR_SC_TX10_SAVE = 10;
  localparam int PVCR_SC_XOVER = 7;
  localparam int PVCR_SC_AN_LPBK = 6;
  localparam int PVCR_SC_XOVER_VAL = 5;
  localparam int PVCR_SC_XOVER_DIS = 4;
  localparam int PVCR_SC_MON_HI = 3;
  localparam int PVCR_SC_MON_LO = 2;
  localparam int PVCR_SC_RSVD_RW = 1;
  localparam int PVCR_SC_POWERDOWN_OVERRIDE_VALUE = 0;
  localparam logic [15:0] PVCR_SC_WMASK = 16'hFF7F;
  localparam logic [15:0] PVCR_SC_RESET = 16'h0000;

  typedef struct packed {
    logic link_pulse_enable;
    logic link_good_forced;
    logic heartbeat_active;
    logic squelch_normal;
    logic jabber_enable;
    logic force_signal_detect;
    logic negotiation_full_power;
    logic ten_meg_tx_power_save;
    logic negotiation_internal_loopback;
    logic auto_crossover_run;
    logic [1:0] vendor_test_sel;
    logic far_end_fault_test;
    logic [1:0] monitor_select;
  } pvcr_ctrl_t;
endpackage

// ==== hw/pvcr_regs.sv ====
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
// Operation
// - reserved read-only bits read zero, writes to them discarded
// - link pulse enable resets 1; 0 stops pulses, forces good link, 10M only
// - heartbeat enable resets 1; ignored in full duplex, 10M only
// - jabber enable resets 1; governs 10M full duplex and loopback
// - polarity status reads 1 while reversed 10M polarity is detected
// - selected power-down test fields take state from override value bit
// - force signal detect makes signal detect good in 100M
// - negotiation power bit: 0 saves power, 1 full power in negotiation
// - 10M transmit power bit: 0 full power, 1 power saving
// - crossover state reads 1 in crossed mode, 0 in straight
// - crossover disable stops auto detection; state follows force value
// - negotiation loopback bit runs internal digital loopback test
module pvcr_regs
  import pvcr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i, // 40 MHz
  input wire logic rst_i, // sync, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // write enable
  input wire logic [ADDR_W-1:0] adr_i, // byte address
  input wire logic [3:0] sel_i, // byte lanes
  input wire logic [31:0] dat_i, // write data
  output logic [31:0] dat_o, // read data
  output logic ack_o, // acknowledge
  input wire logic speed_100_i, // 1 = 100M operation
  input wire logic full_duplex_i, // 1 = full duplex
  input wire logic polarity_reversed_i, // from 10M receive logic
  input wire logic auto_crossover_i, // auto detection result, 1 = crossed
  input wire logic signal_detect_i, // raw 100M signal detect
  output pvcr_ctrl_t ctrl_o, // control levels to the transceiver core
  output logic signal_detect_o, // effective signal detect
  output logic crossover_o, // effective crossover state
  output logic [PVCR_PD_FIELDS-1:0] powerdown_o // per-field power-down
);
  logic [15:0] tb_q;
  logic [15:0] pd_q;
  logic [15:0] sc_q;
  logic pol_q;
  logic xover_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [15:0] wmask_lo;
  logic [15:0] wdat;
  logic req;
  logic wr_go;
  logic adr_ok;
  logic [7:0] idx;

  assign req = cyc_i && stb_i && !ack_q;
  // a write lands only at the edge where the master samples ack high,
  // so an aborted cycle never changes a register
  assign wr_go = cyc_i && stb_i && we_i && ack_q && adr_ok;
  assign adr_ok = (adr_i[1:0] == 2'h0) && (adr_i[ADDR_W-1:10] == '0);
  assign idx = adr_i[9:2];
  assign wmask_lo = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdat = dat_i[15:0];

  // ack in the cycle after the strobe; dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // only writable bits take data; reserved read-only bits stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_q <= PVCR_TB_RESET;
      pd_q <= PVCR_PD_RESET;
      sc_q <= PVCR_SC_RESET;
    end else if (wr_go) begin
      case (idx)
        PVCR_IDX_TENBT: begin
          tb_q <= (tb_q & ~(PVCR_TB_WMASK & wmask_lo)) | (wdat & PVCR_TB_WMASK & wmask_lo);
        end
        PVCR_IDX_PWDN: begin
          pd_q <= (pd_q & ~(PVCR_PD_WMASK & wmask_lo)) | (wdat & PVCR_PD_WMASK & wmask_lo);
        end
        PVCR_IDX_SPEC: begin
          sc_q <= (sc_q & ~(PVCR_SC_WMASK & wmask_lo)) | (wdat & PVCR_SC_WMASK & wmask_lo);
        end
        default: begin
        end
      endcase
    end
  end

  // live status, registered so reads and outputs see one value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_q <= 1'b0;
      xover_q <= 1'b0;
    end else begin
      pol_q <= polarity_reversed_i && !speed_100_i;
      xover_q <= sc_q[PVCR_SC_XOVER_DIS] ? sc_q[PVCR_SC_XOVER_VAL] : auto_crossover_i;
    end
  end

  // unmapped or misaligned addresses read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_q <= 32'h0000_0000;
      if (adr_ok) begin
        case (idx)
          PVCR_IDX_TENBT: dat_q[15:0] <= {tb_q[15:1], pol_q};
          PVCR_IDX_PWDN: dat_q[15:0] <= pd_q;
          PVCR_IDX_SPEC: begin
            dat_q[15:0] <= sc_q;
            dat_q[PVCR_SC_XOVER] <= xover_q;
          end
          default: dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // the reserved writable bits are stored but steer nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
      signal_detect_o <= 1'b0;
      powerdown_o <= '0;
    end else begin
      ctrl_o.link_pulse_enable <= tb_q[PVCR_TB_LINK_PULSE] && !speed_100_i;
      ctrl_o.link_good_forced <= !tb_q[PVCR_TB_LINK_PULSE] && !speed_100_i;
      ctrl_o.heartbeat_active <= tb_q[PVCR_TB_HEARTBEAT] && !speed_100_i
                                 && !full_duplex_i;
      ctrl_o.squelch_normal <= tb_q[PVCR_TB_SQUELCH];
      ctrl_o.jabber_enable <= tb_q[PVCR_TB_JABBER];
      ctrl_o.force_signal_detect <= sc_q[PVCR_SC_FORCE_SD];
      ctrl_o.negotiation_full_power <= sc_q[PVCR_SC_NEG_FULL_PWR];
      ctrl_o.ten_meg_tx_power_save <= sc_q[PVCR_SC_TX10_SAVE];
      ctrl_o.negotiation_internal_loopback <= sc_q[PVCR_SC_AN_LPBK];
      ctrl_o.auto_crossover_run <= !sc_q[PVCR_SC_XOVER_DIS];
      ctrl_o.vendor_test_sel <= {sc_q[PVCR_SC_TEST_A], sc_q[PVCR_SC_TEST_B]};
      ctrl_o.far_end_fault_test <= sc_q[PVCR_SC_FEF];
      ctrl_o.monitor_select <= {sc_q[PVCR_SC_MON_HI], sc_q[PVCR_SC_MON_LO]};
      signal_detect_o <= signal_detect_i || (sc_q[PVCR_SC_FORCE_SD] && speed_100_i);
      powerdown_o <= pd_q[PVCR_PD_FIELDS-1:0] & {PVCR_PD_FIELDS{sc_q[PVCR_SC_POWERDOWN_OVERRIDE_VALUE]}};
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign crossover_o = xover_q;

  // bus steps shared by the handshake properties
  sequence s_bus_take;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  sequence s_read_take;
    cyc_i && stb_i && !ack_o && !we_i;
  endsequence

  sequence s_write_take;
    cyc_i && stb_i && !ack_o && we_i;
  endsequence

  // out of reset and at 10M for two edges, so the status flop has settled
  sequence s_ten_meg_span;
    (!rst_i && !speed_100_i) ##1 !speed_100_i;
  endsequence

  // !rst_i in an antecedent: outputs still show reset values one edge after release

  a_tb_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (tb_q[9:1] == 9'h000) && (tb_q[15] == 1'b0))
    else $error("reserved bits of 10BASE-T register not zero");

  a_pd_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    pd_q[15:9] == 7'h00)
    else $error("reserved bits of power-down register not zero");

  a_link_pulse_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
    !speed_100_i && !tb_q[PVCR_TB_LINK_PULSE] |=> ctrl_o.link_good_forced
    && !ctrl_o.link_pulse_enable)
    else $error("link pulses not stopped");

  a_link_pulse_on: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && !speed_100_i && tb_q[PVCR_TB_LINK_PULSE] |=> ctrl_o.link_pulse_enable
    && !ctrl_o.link_good_forced)
    else $error("link pulses not enabled");

  a_link_fast_off: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_100_i |=> !ctrl_o.link_pulse_enable && !ctrl_o.link_good_forced)
    else $error("link pulse control active at 100M");

  a_heartbeat_fdx: assert property (@(posedge clk_i) disable iff (rst_i)
    full_duplex_i |=> !ctrl_o.heartbeat_active)
    else $error("heartbeat active in full duplex");

  a_heartbeat_fast: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_100_i |=> !ctrl_o.heartbeat_active)
    else $error("heartbeat active at 100M");

  a_heartbeat_on: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && !speed_100_i && !full_duplex_i
    |=> ctrl_o.heartbeat_active == $past(tb_q[PVCR_TB_HEARTBEAT]))
    else $error("heartbeat does not follow its enable");

  a_squelch_level: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> ctrl_o.squelch_normal == $past(tb_q[PVCR_TB_SQUELCH]))
    else $error("squelch level does not follow register");

  a_jabber_level: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> ctrl_o.jabber_enable == $past(tb_q[PVCR_TB_JABBER]))
    else $error("jabber enable does not follow register");

  a_polarity_track: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ten_meg_span |-> pol_q == $past(polarity_reversed_i))
    else $error("polarity status does not follow detector");

  a_polarity_fast: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_100_i |=> !pol_q)
    else $error("polarity status set at 100M");

  a_polarity_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_take ##0 (adr_ok && idx == PVCR_IDX_TENBT) |=> dat_o[0] == $past(pol_q)
    && dat_o[15] == 1'b0 && dat_o[9:1] == 9'h000)
    else $error("10BASE-T register read wrong");

  a_powerdown_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 powerdown_o == ($past(pd_q[8:0]) & {9{$past(sc_q[0])}}))
    else $error("power-down override mismatch");

  a_powerdown_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && !sc_q[PVCR_SC_POWERDOWN_OVERRIDE_VALUE] |=> powerdown_o == 9'h000)
    else $error("power-down active with override value zero");

  a_sig_detect_force: assert property (@(posedge clk_i) disable iff (rst_i)
    sc_q[PVCR_SC_FORCE_SD] && speed_100_i |=> signal_detect_o)
    else $error("forced signal detect not good");

  a_sig_detect_raw: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && !sc_q[PVCR_SC_FORCE_SD] |=> signal_detect_o == $past(signal_detect_i))
    else $error("signal detect does not follow raw input");

  a_neg_power: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> ctrl_o.negotiation_full_power == $past(sc_q[PVCR_SC_NEG_FULL_PWR]))
    else $error("negotiation power mode does not follow register");

  a_tx_power: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> ctrl_o.ten_meg_tx_power_save == $past(sc_q[PVCR_SC_TX10_SAVE]))
    else $error("10M transmit power mode does not follow register");

  a_xover_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && adr_ok && idx == PVCR_IDX_SPEC |=> ack_o
    && dat_o[PVCR_SC_XOVER] == $past(xover_q))
    else $error("crossover state read wrong");

  a_xover_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    sc_q[PVCR_SC_XOVER_DIS] |=> crossover_o == $past(sc_q[PVCR_SC_XOVER_VAL]))
    else $error("forced crossover value not applied");

  a_xover_auto: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && !sc_q[PVCR_SC_XOVER_DIS] |=> crossover_o == $past(auto_crossover_i)
    && ctrl_o.auto_crossover_run)
    else $error("automatic crossover result not applied");

  a_an_loopback: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> ctrl_o.negotiation_internal_loopback == $past(sc_q[PVCR_SC_AN_LPBK]))
    else $error("negotiation loopback does not follow register");

  a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

  a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_take |=> s_ack_pulse)
    else $error("request not answered by one ack pulse");

  a_wr_at_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_take |=> $stable(tb_q) && $stable(pd_q) && $stable(sc_q))
    else $error("write landed before ack");

  a_tb_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_take ##1 (wr_go && idx == PVCR_IDX_TENBT && sel_i[1:0] == 2'h3)
    |=> tb_q == ($past(wdat) & PVCR_TB_WMASK))
    else $error("10BASE-T register write wrong");

  a_pd_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_take ##1 (wr_go && idx == PVCR_IDX_PWDN && sel_i[1:0] == 2'h3)
    |=> pd_q == ($past(wdat) & PVCR_PD_WMASK))
    else $error("power-down register write wrong");

  a_sc_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_take ##1 (wr_go && idx == PVCR_IDX_SPEC && sel_i[1:0] == 2'h3)
    |=> sc_q == ($past(wdat) & PVCR_SC_WMASK))
    else $error("configuration register write wrong");

  a_lane_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && idx == PVCR_IDX_SPEC && !sel_i[1] |=> $stable(sc_q[15:8]))
    else $error("unselected byte lane written");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_take ##0 !adr_ok |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import pvcr_pkg::*;
  localparam logic [31:0] ADRS [5] = '{32'h48, 32'h4C, 32'h50, 32'h54, 32'h4A};
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, r, rv;
  logic [3:0] sel_i = 4'h0, sl = 4'hF;
  logic spd = 1'b0, fd = 1'b0, pol = 1'b0, acx = 1'b1, sd = 1'b0;
  logic signal_detect_o, crossover_o;
  logic [8:0] powerdown_o;
  pvcr_ctrl_t ctrl_o, ec;
  logic [15:0] t, p, s;
  int error_cnt = 0, checked = 0, seed = 50852;
  always #12.5 clk_i = ~clk_i;
  pvcr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .speed_100_i(spd), .full_duplex_i(fd), .polarity_reversed_i(pol),
    .auto_crossover_i(acx), .signal_detect_i(sd), .ctrl_o(ctrl_o),
    .signal_detect_o(signal_detect_o), .crossover_o(crossover_o), .powerdown_o(powerdown_o));
  task automatic complete_run;
    $display("counts: checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled at a rising edge
  task automatic wb(input logic w, input logic [31:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, d};
    sel_i <= sl;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      error_cnt++;
      complete_run;
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  function automatic logic xo();
    return s[4] ? s[5] : acx;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    case (a)
      32'h48: return {16'h0, t & PVCR_TB_WMASK} | {31'h0, pol & ~spd};
      32'h4C: return {16'h0, p & PVCR_PD_WMASK};
      32'h50: return {16'h0, s & PVCR_SC_WMASK} | {24'h0, xo(), 7'h0};
      default: return 32'h0;
    endcase
  endfunction
  task automatic rdall;
    foreach (ADRS[k]) begin
      wb(1'b0, ADRS[k], 16'h0);
      chk("read data", r, exp_rd(ADRS[k]));
    end
  endtask
  task automatic outs;
    ec = '{t[14] & ~spd, ~t[14] & ~spd, t[13] & ~spd & ~fd, t[12], t[11], s[13], s[11],
      s[10], s[6], ~s[4], s[15:14], s[12], s[3:2]};
    chk("ctrl", {17'h0, ctrl_o}, {17'h0, ec});
    chk("sd", {31'h0, signal_detect_o}, {31'h0, sd | (s[13] & spd)});
    chk("xover", {31'h0, crossover_o}, {31'h0, xo()});
    chk("pd", {23'h0, powerdown_o}, {23'h0, p[8:0] & {9{s[0]}}});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t = PVCR_TB_RESET;
    p = 16'h0;
    s = 16'h0;
    rdall;
    outs;
    $display("test reset values done");
    // ones into read-only reserved places; the writable reserved bit kept at zero
    t = 16'hFBFF;
    wb(1'b1, 32'h48, t);
    wb(1'b1, 32'h54, 16'hFFFF);
    wb(1'b1, 32'h4A, 16'hFFFF);
    rdall;
    $display("test reserved and unmapped done");
    // byte lanes: a write changes only the selected half of a register
    sl = 4'h2;
    wb(1'b1, 32'h4C, 16'hFFFF);
    sl = 4'h1;
    wb(1'b1, 32'h50, 16'hFFF1);
    sl = 4'hF;
    p = 16'h0100;
    s = 16'h00F1;
    repeat (3) @(posedge clk_i);
    outs;
    rdall;
    $display("test byte lanes done");
    for (int i = 0; i < 24; i++) begin
      rv = $random(seed);
      @(posedge clk_i);
      {spd, fd, pol, acx, sd} <= rv[4:0];
      t = (i == 0) ? 16'h0 : 16'($random(seed)) & 16'hFBFF;
      p = (i == 1) ? 16'hFFFF : 16'($random(seed));
      s = (i == 1) ? 16'h2FF1 : 16'($random(seed)) & 16'h2FF1;
      wb(1'b1, 32'h48, t);
      wb(1'b1, 32'h4C, p);
      wb(1'b1, 32'h50, s);
      repeat (3) @(posedge clk_i);
      outs;
      rdall;
    end
    $display("test random traffic done");
    complete_run;
  end
endmodule
